// file: hw/fpe_flash_ctrl.sv
// Summary of operation
// - Programming only clears bits; ones come back only through erase.
// - Erase covers a whole 512-byte page, or the whole 128-byte scratchpad, and fills it with 0xFF.
// - Writes and erases are timed internally: erase 14 ms, byte 60 us.
// - CPU is stalled during an operation; other logic keeps running.
// - Interrupts arriving during an operation are held, released afterwards.
// - Redirect bit set steers data-move writes to flash, else to external RAM.
// - Redirect bit stays set until software clears it.
// - Data-move reads always go to external RAM; flash is read by code reads.
// - Software writes and erases need the access enable bit.
// - Enable, erase arm and redirect set: a write erases its containing page.
// - With erase arm cleared, redirected writes program the addressed byte.
// - Flash is programmed a byte at a time, by debug port or software.
// - Scratchpad of 128 bytes at 0x00-0x7F replaces main flash when selected.
// - Instruction fetch never reads the scratchpad.
// - Main array is 64 k or 32 k bytes, plus the 128-byte scratchpad.
// - Top 1024 bytes, 0xFC00-0xFFFF, of the large array are reserved.
`timescale 1ns/1ps
module fpe_flash_ctrl #(
  parameter int unsigned ERASE_CYCLES  = fpe_pkg::ERASE_CYCLES_DEF,
  parameter bit          LARGE_VARIANT = 1'b1
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire fpe_pkg::fpe_movx_type     movx_req,
  output fpe_pkg::fpe_movx_type          external_data_ram_req,
  input  wire fpe_pkg::fpe_code_req_type code_req,
  output logic      [7:0]                code_rdata,
  output logic                           code_valid,
  input  wire fpe_pkg::fpe_dbg_req_type  dbg_req,
  output logic                           cpu_stall,
  input  wire logic [7:0]                irq_in,
  input  wire logic [7:0]                irq_ack,
  output logic      [7:0]                irq_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  fpe_pkg::fpe_state_type      state_q;
  fpe_pkg::fpe_state_type      state_d;
  logic [fpe_pkg::CNT_W-1:0]   cnt_q;
  logic [15:0]                 op_addr_q;
  logic [7:0]                  op_data_q;
  logic                        op_scr_q;
  logic                        redirect_q;
  logic                        erase_arm_q;
  logic                        scr_sel_q;
  logic                        access_en_q;
  logic                        refused_q;
  logic                        last_erase_q;
  logic [7:0]                  irq_pend_q;
  logic [31:0]                 prdata_q;
  logic                        pready_q;
  logic                        pslverr_q;
  fpe_pkg::fpe_movx_type       external_data_ram_q;
  logic [7:0]                  code_rdata_q;
  logic                        code_valid_q;
  logic [7:0]                  irq_out_q;
  logic [7:0]                  main_mem [fpe_pkg::MAIN_BYTES_LARGE];
  logic [7:0]                  scr_mem [fpe_pkg::SCR_BYTES];
  logic                        start_prog;
  logic                        start_erase;
  logic [15:0]                 start_addr;
  logic [7:0]                  start_data;
  logic                        sw_refuse;
  logic                        op_done;
  logic                        fill_on;
  logic                        main_we;
  logic                        scr_we;
  logic [15:0]                 main_wa;
  logic [6:0]                  scr_wa;
  logic                        apb_acc;
  logic                        apb_valid;
  logic                        apb_commit;
  logic [31:0]                 apb_rval;

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic fpe_writable(input logic [15:0] a, input logic scr);
    if (scr)
      return 1'b1;
    else if (LARGE_VARIANT)
      return a < fpe_pkg::RESERVED_BASE;
    else
      return a[15] == 1'b0;
  endfunction : fpe_writable

  // ****************************************************************
  // Operation start
  // ****************************************************************
  always_comb
  begin
    start_prog  = 1'b0;
    start_erase = 1'b0;
    start_addr  = movx_req.addr;
    start_data  = movx_req.data;
    sw_refuse   = 1'b0;
    if (state_q == fpe_pkg::FPE_IDLE)
    begin
      if (dbg_req.wr || dbg_req.erase)
      begin
        start_addr  = dbg_req.addr;
        start_data  = dbg_req.data;
        start_erase = dbg_req.erase && fpe_writable(dbg_req.addr, scr_sel_q);
        start_prog  = !dbg_req.erase && fpe_writable(dbg_req.addr, scr_sel_q);
      end
      else if (movx_req.wr && redirect_q)
      begin
        if (!access_en_q || !fpe_writable(movx_req.addr, scr_sel_q))
          sw_refuse = 1'b1;
        else if (erase_arm_q)
          start_erase = 1'b1;
        else
          start_prog = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign op_done = (state_q == fpe_pkg::FPE_PROG &&
                    cnt_q == fpe_pkg::CNT_W'(fpe_pkg::WRITE_CYCLES - 1)) ||
                   (state_q == fpe_pkg::FPE_ERASE &&
                    cnt_q == fpe_pkg::CNT_W'(ERASE_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      fpe_pkg::FPE_IDLE:
        if (start_erase)
          state_d = fpe_pkg::FPE_ERASE;
        else if (start_prog)
          state_d = fpe_pkg::FPE_PROG;
      fpe_pkg::FPE_PROG,
      fpe_pkg::FPE_ERASE:
        if (op_done)
          state_d = fpe_pkg::FPE_IDLE;
      default:
        state_d = fpe_pkg::FPE_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q      <= fpe_pkg::FPE_IDLE;
      cnt_q        <= '0;
      op_addr_q    <= 16'h0000;
      op_data_q    <= 8'hFF;
      op_scr_q     <= 1'b0;
      last_erase_q <= 1'b0;
      cpu_stall    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cpu_stall <= state_d != fpe_pkg::FPE_IDLE;
      if (state_q == fpe_pkg::FPE_IDLE)
      begin
        cnt_q <= '0;
        if (start_prog || start_erase)
        begin
          op_addr_q    <= start_addr;
          op_data_q    <= start_data;
          op_scr_q     <= scr_sel_q;
          last_erase_q <= start_erase;
        end
      end
      else
        cnt_q <= op_done ? '0 : cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // Array write port
  // ****************************************************************
  always_comb
  begin
    fill_on = op_scr_q ? (cnt_q < fpe_pkg::CNT_W'(fpe_pkg::SCR_BYTES))
                       : (cnt_q < fpe_pkg::CNT_W'(fpe_pkg::PAGE_BYTES));
    main_we = 1'b0;
    scr_we  = 1'b0;
    main_wa = op_addr_q;
    scr_wa  = op_addr_q[fpe_pkg::SCR_W-1:0];
    if (state_q == fpe_pkg::FPE_PROG && cnt_q == '0)
    begin
      main_we = !op_scr_q;
      scr_we  = op_scr_q;
    end
    else if (state_q == fpe_pkg::FPE_ERASE && fill_on)
    begin
      main_we = !op_scr_q;
      scr_we  = op_scr_q;
      main_wa = {op_addr_q[15:fpe_pkg::PAGE_W], cnt_q[fpe_pkg::PAGE_W-1:0]};
      scr_wa  = cnt_q[fpe_pkg::SCR_W-1:0];
    end
  end

  always_ff @(posedge pclk)
  begin
    if (main_we)
      main_mem[main_wa] <= (state_q == fpe_pkg::FPE_ERASE) ? fpe_pkg::ERASED_BYTE
                           : main_mem[main_wa] & op_data_q;
    if (scr_we)
      scr_mem[scr_wa] <= (state_q == fpe_pkg::FPE_ERASE) ? fpe_pkg::ERASED_BYTE
                         : scr_mem[scr_wa] & op_data_q;
  end

  // ****************************************************************
  // Code read port
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_rdata_q <= 8'h00;
      code_valid_q <= 1'b0;
    end
    else
    begin
      code_valid_q <= code_req.rd && state_q == fpe_pkg::FPE_IDLE;
      if (code_req.rd && state_q == fpe_pkg::FPE_IDLE)
      begin
        if (scr_sel_q && !code_req.fetch)
          code_rdata_q <= scr_mem[code_req.addr[fpe_pkg::SCR_W-1:0]];
        else if (LARGE_VARIANT || !code_req.addr[15])
          code_rdata_q <= main_mem[code_req.addr];
        else
          code_rdata_q <= fpe_pkg::ERASED_BYTE;
      end
    end
  end

  // ****************************************************************
  // External data RAM path
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      external_data_ram_q <= '0;
    else
    begin
      external_data_ram_q.rd   <= movx_req.rd && state_q == fpe_pkg::FPE_IDLE;
      external_data_ram_q.wr   <= movx_req.wr && !redirect_q && state_q == fpe_pkg::FPE_IDLE;
      external_data_ram_q.addr <= movx_req.addr;
      external_data_ram_q.data <= movx_req.data;
    end
  end

  // ****************************************************************
  // Stall and interrupt hold
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_pend_q <= 8'h00;
      irq_out_q  <= 8'h00;
    end
    else
    begin
      irq_pend_q <= (irq_pend_q & ~irq_ack) | irq_in;
      irq_out_q  <= (state_d == fpe_pkg::FPE_IDLE) ? (irq_pend_q & ~irq_ack) | irq_in
                    : 8'h00;
    end
  end

  // ****************************************************************
  // Register file over APB
  // ****************************************************************
  assign apb_acc    = psel && penable;
  assign apb_valid  = paddr == fpe_pkg::PSC_OFFSET || paddr == fpe_pkg::FTC_OFFSET ||
                      paddr == fpe_pkg::STAT_OFFSET;
  assign apb_commit = apb_acc && pready_q && pwrite && apb_valid;

  always_comb
  begin
    apb_rval = 32'h0000_0000;
    if (paddr == fpe_pkg::PSC_OFFSET)
    begin
      apb_rval[fpe_pkg::PSC_REDIRECT_BIT] = redirect_q;
      apb_rval[fpe_pkg::PSC_ERASE_BIT]    = erase_arm_q;
      apb_rval[fpe_pkg::PSC_SCR_BIT]      = scr_sel_q;
    end
    else if (paddr == fpe_pkg::FTC_OFFSET)
      apb_rval[fpe_pkg::FTC_ENABLE_BIT] = access_en_q;
    else if (paddr == fpe_pkg::STAT_OFFSET)
    begin
      apb_rval[fpe_pkg::STAT_BUSY_BIT]   = state_q != fpe_pkg::FPE_IDLE;
      apb_rval[fpe_pkg::STAT_ERASE_BIT]  = last_erase_q;
      apb_rval[fpe_pkg::STAT_REFUSE_BIT] = refused_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= apb_acc && !pready_q;
      pslverr_q <= apb_acc && !pready_q && !apb_valid;
      prdata_q  <= (apb_acc && !pready_q && !pwrite) ? apb_rval : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      redirect_q  <= fpe_pkg::PSC_RESET[fpe_pkg::PSC_REDIRECT_BIT];
      erase_arm_q <= fpe_pkg::PSC_RESET[fpe_pkg::PSC_ERASE_BIT];
      scr_sel_q   <= fpe_pkg::PSC_RESET[fpe_pkg::PSC_SCR_BIT];
      access_en_q <= fpe_pkg::FTC_RESET;
    end
    else if (apb_commit && paddr == fpe_pkg::PSC_OFFSET)
    begin
      redirect_q  <= pwdata[fpe_pkg::PSC_REDIRECT_BIT];
      erase_arm_q <= pwdata[fpe_pkg::PSC_ERASE_BIT];
      scr_sel_q   <= pwdata[fpe_pkg::PSC_SCR_BIT];
    end
    else if (apb_commit && paddr == fpe_pkg::FTC_OFFSET)
      access_en_q <= pwdata[fpe_pkg::FTC_ENABLE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refused_q <= 1'b0;
    else if (sw_refuse)
      refused_q <= 1'b1;
    else if (apb_commit && paddr == fpe_pkg::STAT_OFFSET && pwdata[fpe_pkg::STAT_REFUSE_BIT])
      refused_q <= 1'b0;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign external_data_ram_req   = external_data_ram_q;
  assign code_rdata = code_rdata_q;
  assign code_valid = code_valid_q;
  assign irq_out    = irq_out_q;

endmodule : fpe_flash_ctrl

// file: hw/fpe_pkg.sv
// ****************************************************************
// Flash sequencer constants and carriers
// ****************************************************************
package fpe_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned MAIN_BYTES_LARGE = 65536;
  localparam int unsigned MAIN_BYTES_SMALL = 32768;
  localparam int unsigned SCR_BYTES        = 128;
  localparam int unsigned PAGE_BYTES       = 512;
  localparam int unsigned ADDR_W           = 16;
  localparam int unsigned PAGE_W           = 9;
  localparam int unsigned SCR_W            = 7;
  localparam logic [15:0] RESERVED_BASE    = 16'hFC00;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_KHZ          = 40000;
  localparam int unsigned ERASE_TIME_MS    = 14;
  localparam int unsigned WRITE_TIME_US    = 60;
  localparam int unsigned ERASE_CYCLES_DEF = ERASE_TIME_MS * CLK_KHZ;
  localparam int unsigned WRITE_CYCLES     = (WRITE_TIME_US * CLK_KHZ) / 1000;
  localparam int unsigned CNT_W            = 20;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] PSC_OFFSET       = 32'h0000_0000;
  localparam logic [31:0] FTC_OFFSET       = 32'h0000_0004;
  localparam logic [31:0] STAT_OFFSET      = 32'h0000_0008;
  localparam int unsigned PSC_REDIRECT_BIT = 0;
  localparam int unsigned PSC_ERASE_BIT    = 1;
  localparam int unsigned PSC_SCR_BIT      = 2;
  localparam int unsigned FTC_ENABLE_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_ERASE_BIT   = 1;
  localparam int unsigned STAT_REFUSE_BIT  = 2;
  localparam logic [2:0]  PSC_RESET        = 3'h0;
  localparam logic        FTC_RESET        = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    FPE_IDLE  = 2'b00,
    FPE_PROG  = 2'b01,
    FPE_ERASE = 2'b10
  } fpe_state_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpe_movx_type;

  typedef struct packed {
    logic        rd;
    logic        fetch;
    logic [15:0] addr;
  } fpe_code_req_type;

  typedef struct packed {
    logic        wr;
    logic        erase;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpe_dbg_req_type;

endpackage : fpe_pkg

// file: tb/fpe_flash_ctrl_checker.sv
`timescale 1ns/1ps
module fpe_flash_ctrl_checker #(
  parameter int unsigned ERASE_CYCLES = 600
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire fpe_pkg::fpe_movx_type     movx_req,
  input wire fpe_pkg::fpe_movx_type     external_data_ram_req,
  input wire fpe_pkg::fpe_code_req_type code_req,
  input wire logic                      code_valid,
  input wire fpe_pkg::fpe_dbg_req_type  dbg_req,
  input wire logic                      cpu_stall,
  input wire logic [7:0]                irq_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned stall_n_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      stall_n_q <= 0;
    else if (cpu_stall)
      stall_n_q <= stall_n_q + 1;
    else
      stall_n_q <= 0;
  sequence apb_acc;
    psel && penable && !pready;
  endsequence
  sequence one_ready;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (apb_acc |=> one_ready)
    else $error("pready not a single pulse after access");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero while idle");
  stall_len_a: assert property ($fell(cpu_stall) |->
    stall_n_q == fpe_pkg::WRITE_CYCLES || stall_n_q == ERASE_CYCLES)
    else $error("stall length wrong");
  stall_cause_a: assert property ($rose(cpu_stall) |->
    $past(movx_req.wr || dbg_req.wr || dbg_req.erase))
    else $error("stall without write request");
  irq_hold_a: assert property (cpu_stall |-> irq_out == 8'h0)
    else $error("interrupt passed during stall");
  external_data_ram_wr_cause_a: assert property (external_data_ram_req.wr |->
    $past(movx_req.wr && !cpu_stall))
    else $error("external ram write without cause");
  external_data_ram_read_a: assert property (movx_req.rd && !cpu_stall |=>
    external_data_ram_req.rd && external_data_ram_req.addr == $past(movx_req.addr))
    else $error("data-move read not sent to external ram");
  code_answer_a: assert property (code_req.rd && !cpu_stall |=> code_valid)
    else $error("code read unanswered");
endmodule : fpe_flash_ctrl_checker

bind fpe_flash_ctrl fpe_flash_ctrl_checker #(.ERASE_CYCLES(ERASE_CYCLES))
  u_fpe_flash_ctrl_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .movx_req(movx_req), .external_data_ram_req(external_data_ram_req), .code_req(code_req),
  .code_valid(code_valid), .dbg_req(dbg_req), .cpu_stall(cpu_stall),
  .irq_out(irq_out));

// file: tb/fpe_cpu_model.sv
`timescale 1ns/1ps
module fpe_cpu_model (
  input  wire logic                  pclk,
  input  wire logic                  cpu_stall,
  input  wire fpe_pkg::fpe_movx_type external_data_ram_req,
  input  wire logic [7:0]            code_rdata,
  input  wire logic                  code_valid,
  output fpe_pkg::fpe_movx_type      movx_req,
  output fpe_pkg::fpe_code_req_type  code_req
);
  // Model takes no interrupts, so redirect windows run undisturbed
  initial
  begin
    movx_req = '0;
    code_req = '0;
  end
  // Data-move cycle; no new request until the stall drops
  task automatic movx(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output fpe_pkg::fpe_movx_type x, output int n);
    int k;
    @(posedge pclk);
    movx_req <= {w, ~w, a, d};
    @(posedge pclk);
    movx_req <= {2'h0, ~a, ~d};
    @(posedge pclk);
    x = external_data_ram_req;
    n = 0;
    for (k = 0; k < 4000 && cpu_stall === 1'h1; k++)
    begin
      n++;
      @(posedge pclk);
    end
    if (cpu_stall !== 1'h0)
      tb_top.hang();
  endtask : movx
  task automatic code_rd(input logic f, input logic [15:0] a, output logic [7:0] d);
    int k;
    @(posedge pclk);
    code_req <= {1'h1, f, a};
    @(posedge pclk);
    code_req <= {1'h0, ~f, ~a};
    for (k = 0; k < 8; k++)
    begin
      @(posedge pclk);
      if (code_valid === 1'h1)
        break;
    end
    if (code_valid !== 1'h1)
      tb_top.hang();
    d = code_rdata;
  endtask : code_rd
endmodule : fpe_cpu_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned ERASE_N = 600;
  localparam logic [31:0] PSC = fpe_pkg::PSC_OFFSET;
  localparam logic [31:0] FTC = fpe_pkg::FTC_OFFSET;
  localparam logic [31:0] STA = fpe_pkg::STAT_OFFSET;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic [31:0]               paddr, pwdata, prdata, rd;
  logic                      pready, pslverr, cpu_stall, code_valid, er;
  logic [7:0]                code_rdata, irq_in, irq_ack, irq_out, cb;
  fpe_pkg::fpe_movx_type     movx_req, external_data_ram_req, xr;
  fpe_pkg::fpe_code_req_type code_req;
  fpe_pkg::fpe_dbg_req_type  dbg_req;
  int                        n_fail, checked, sn;
  always #12.5 pclk = ~pclk;
  fpe_flash_ctrl #(.ERASE_CYCLES(ERASE_N)) u_fpe_flash_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .movx_req(movx_req), .external_data_ram_req(external_data_ram_req),
    .code_req(code_req), .code_rdata(code_rdata), .code_valid(code_valid),
    .dbg_req(dbg_req), .cpu_stall(cpu_stall), .irq_in(irq_in),
    .irq_ack(irq_ack), .irq_out(irq_out));
  fpe_cpu_model u_fpe_cpu_model (.pclk(pclk), .cpu_stall(cpu_stall),
    .external_data_ram_req(external_data_ram_req), .code_rdata(code_rdata), .code_valid(code_valid),
    .movx_req(movx_req), .code_req(code_req));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic hang();
    n_fail++;
    tally_and_finish();
  endtask : hang
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'h1)
        break;
    end
    if (pready !== 1'h1)
      hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wreg
  task automatic rreg(input logic [31:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(e, rd);
  endtask : rreg
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    u_fpe_cpu_model.movx(1'h1, a, d, xr, sn);
  endtask : mw
  task automatic dbg(input logic e, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    dbg_req <= {~e, e, a, d};
    @(posedge pclk);
    dbg_req <= {2'h0, ~a, ~d};
    @(posedge pclk);
    sn = 0;
    for (k = 0; k < 4000 && cpu_stall === 1'h1; k++)
    begin
      sn++;
      @(posedge pclk);
    end
    if (cpu_stall !== 1'h0)
      hang();
  endtask : dbg
  task automatic crd(input logic f, input logic [15:0] a, input logic [7:0] e);
    u_fpe_cpu_model.code_rd(f, a, cb);
    chk({24'h0, e}, {24'h0, cb});
  endtask : crd
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rreg(PSC, 32'h0);
    rreg(FTC, 32'h0);
    rreg(STA, 32'h0);
    wreg(32'h0000_000C, 32'h0000_0007);
    chk(32'h1, {31'h0, er});
    rreg(32'h0000_000C, 32'h0);
  endtask : t_regs
  task automatic t_erase();
    wreg(FTC, 32'h1);
    wreg(PSC, 32'h2);
    wreg(PSC, 32'h3);
    mw(16'h0234, 8'h00);
    chk(ERASE_N, sn);
    chk(32'h0, {31'h0, xr.wr});
    rreg(STA, 32'h2);
    crd(1'h0, 16'h0200, 8'hFF);
    crd(1'h0, 16'h03FF, 8'hFF);
    wreg(PSC, 32'h1);
    rreg(PSC, 32'h1);
  endtask : t_erase
  task automatic t_prog();
    mw(16'h0210, 8'hA5);
    chk(fpe_pkg::WRITE_CYCLES, sn);
    crd(1'h0, 16'h0210, 8'hA5);
    mw(16'h0210, 8'h0F);
    crd(1'h0, 16'h0210, 8'h05);
    wreg(FTC, 32'h0);
    dbg(1'h1, 16'h0300, 8'h00);
    chk(ERASE_N, sn);
    crd(1'h0, 16'h0210, 8'hFF);
    dbg(1'h0, 16'h0211, 8'h3C);
    chk(fpe_pkg::WRITE_CYCLES, sn);
    crd(1'h0, 16'h0211, 8'h3C);
  endtask : t_prog
  task automatic t_refuse();
    mw(16'h0212, 8'h00);
    chk(32'h0, sn);
    chk(32'h0, {31'h0, xr.wr});
    crd(1'h0, 16'h0212, 8'hFF);
    rreg(STA, 32'h4);
    wreg(STA, 32'h4);
    rreg(STA, 32'h0);
    wreg(FTC, 32'h1);
    mw(16'hFC00, 8'h00);
    chk(32'h0, sn);
    rreg(STA, 32'h4);
    wreg(STA, 32'h4);
  endtask : t_refuse
  task automatic t_route();
    wreg(PSC, 32'h0);
    mw(16'h0213, 8'h55);
    chk({6'h0, 2'h2, 16'h0213, 8'h55}, {6'h0, xr});
    chk(32'h0, sn);
    crd(1'h0, 16'h0213, 8'hFF);
    wreg(PSC, 32'h1);
    u_fpe_cpu_model.movx(1'h0, 16'h0213, 8'h00, xr, sn);
    chk({15'h0, 1'h1, 16'h0213}, {15'h0, xr.rd, xr.addr});
    chk(32'h0, sn);
  endtask : t_route
  task automatic t_scratch();
    wreg(PSC, 32'h3);
    mw(16'h0000, 8'h00);
    wreg(PSC, 32'h7);
    mw(16'h0000, 8'h00);
    chk(ERASE_N, sn);
    wreg(PSC, 32'h5);
    mw(16'h0005, 8'h5A);
    crd(1'h0, 16'h0005, 8'h5A);
    crd(1'h1, 16'h0005, 8'hFF);
    wreg(PSC, 32'h1);
    crd(1'h0, 16'h0005, 8'hFF);
  endtask : t_scratch
  task automatic t_irq();
    fork
      mw(16'h0220, 8'hF0);
      begin
        repeat (20) @(posedge pclk);
        irq_in <= 8'h04;
        @(posedge pclk);
        irq_in <= 8'h00;
        repeat (5) @(posedge pclk);
        chk(32'h0, {24'h0, irq_out});
        rreg(PSC, 32'h1);
        chk(32'h1, {31'h0, cpu_stall});
      end
    join
    @(posedge pclk);
    chk(32'h4, {24'h0, irq_out});
    irq_ack <= 8'h04;
    @(posedge pclk);
    irq_ack <= 8'h00;
    repeat (3) @(posedge pclk);
    chk(32'h0, {24'h0, irq_out});
  endtask : t_irq
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    dbg_req = '0;
    irq_in = 8'h0;
    irq_ack = 8'h0;
    n_fail = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_erase();
    t_prog();
    t_refuse();
    t_route();
    t_scratch();
    t_irq();
    tally_and_finish();
  end
endmodule : tb_top
